// [pkg/dde_map.vh]
// Purpose: constants for the decrement/divide execution datapath
// Assumes: 8-bit core, opcodes as decoded by the core front end
// Notes: included by both design files
`ifndef DDE_MAP_VH
`define DDE_MAP_VH

// opcodes and masks
`define DDE_OP_DEC_ACC 8'h14
`define DDE_OP_DEC_DIR 8'h15
`define DDE_OP_DEC_IND 8'h16
`define DDE_MASK_IND 8'hFE
`define DDE_OP_DEC_REG 8'h18
`define DDE_MASK_REG 8'hF8
`define DDE_OP_DIV 8'h84

// widths and constants
`define DDE_W 8
`define DDE_ONE 8'h01
`define DDE_ZERO 8'h00
`define DDE_ALL_ONES 8'hFF
`define DDE_DIV_CYCLES 4
`define DDE_CNT_W 3
`define DDE_CNT_LAST 3'h3
`define DDE_CNT_ZERO 3'h0
`define DDE_STEPS_PER_CYCLE 2

// operand source codes
`define DDE_SRC_ACC 2'h0
`define DDE_SRC_REG 2'h1
`define DDE_SRC_DIR 2'h2
`define DDE_SRC_IND 2'h3

`endif

// [src/dde_div_step.v]
// Purpose: two restoring-division steps for the divide sequencer
// Assumes: divisor is non-zero when the result is used
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "dde_map.vh"

module dde_div_step (
  // partial state in
  input wire [7:0] rem_in,
  input wire [7:0] quo_in,
  input wire [7:0] divisor,
  // partial state out
  output reg [7:0] rem_out,
  output reg [7:0] quo_out
);

  reg [8:0] trial;
  reg [7:0] r;
  reg [7:0] q;
  integer i;

  always @*
  begin
    trial = 9'h000;
    r = rem_in;
    q = quo_in;
    for (i = 0; i < `DDE_STEPS_PER_CYCLE; i = i + 1)
    begin
      // shift next dividend bit in from the top of the quotient register
      trial = {r, q[7]};
      q = {q[6:0], 1'b0};
      if (trial >= {1'b0, divisor})
      begin
        trial = trial - {1'b0, divisor};
        q[0] = 1'b1;
      end
      r = trial[7:0];
    end
    rem_out = r;
    quo_out = q;
  end

endmodule

`default_nettype wire

// [src/dde_exec.v]
// Purpose: execution datapath for byte decrement and unsigned 8x8 divide
// Assumes: the core presents one instruction per start pulse, with operands
//          already fetched; the core writes results back from the *_wr ports
// Notes: one clock cycle stands for one machine cycle
// Operation
// - decrement subtracts one and writes back, zero wrapping to all ones.
// - decrement leaves carry, auxiliary carry and overflow untouched.
// - decrement works on accumulator, working register, direct and indirect bytes.
// - an output-port operand is taken from its output latch, not from pins.
// - accumulator decrement is opcode 0001 0100, one cycle.
// - working-register decrement is 0001 1rrr, one byte, one cycle.
// - direct decrement is 0001 0101 plus an address byte, one cycle.
// - indirect decrement is 0001 011i, one byte, one cycle, via a pointer register.
// - divide treats accumulator and secondary register as unsigned bytes.
// - after divide the accumulator holds quotient, secondary holds remainder.
// - a non-zero divisor clears carry and overflow.
// - a zero divisor sets overflow, clears carry, results undefined.
// - divide is opcode 1000 0100 and takes four machine cycles; here results land five cycles after the start cycle, after four busy cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dde_map.vh"

module dde_exec (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // instruction from decode
  input wire start,
  input wire [7:0] opcode,
  input wire [7:0] direct_addr,
  // operand values from the core
  input wire [7:0] acc_in,
  input wire [7:0] b_in,
  input wire [7:0] working_register_in,
  input wire [7:0] pointer_register0,
  input wire [7:0] pointer_register1,
  input wire [7:0] mem_rdata,
  input wire dir_is_port,
  input wire [7:0] port_latch,
  input wire carry_in,
  input wire aux_carry_in,
  input wire overflow_flag_in,
  // operand addressing toward the core
  output wire [2:0] working_register_sel,
  output wire [7:0] mem_raddr,
  // results
  output reg acc_wr,
  output reg [7:0] acc_out,
  output reg b_wr,
  output reg [7:0] b_out,
  output reg working_register_wr,
  output reg [2:0] working_register_wsel,
  output reg [7:0] working_register_out,
  output reg mem_wr,
  output reg [7:0] mem_waddr,
  output reg [7:0] mem_wdata,
  output reg flags_wr,
  output reg carry_out,
  output reg aux_carry_out,
  output reg overflow_flag_out,
  // sequencing
  output wire busy,
  output reg done,
  output wire illegal
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // class code: divide, decrement, or not executed by this block
  function [2:0] dde_decode;
    input [7:0] op;
    begin
      // bit 0: decrement form, bit 1 unused, bit 2 divide
      if (op == `DDE_OP_DIV)
        dde_decode = 3'h4;
      else if (op == `DDE_OP_DEC_ACC || op == `DDE_OP_DEC_DIR
               || (op & `DDE_MASK_IND) == `DDE_OP_DEC_IND
               || (op & `DDE_MASK_REG) == `DDE_OP_DEC_REG)
        dde_decode = 3'h1;
      else
        dde_decode = 3'h0;
    end
  endfunction

  function [1:0] dde_src;
    input [7:0] op;
    begin
      if (op == `DDE_OP_DEC_ACC)
        dde_src = `DDE_SRC_ACC;
      else if (op == `DDE_OP_DEC_DIR)
        dde_src = `DDE_SRC_DIR;
      else if ((op & `DDE_MASK_REG) == `DDE_OP_DEC_REG)
        dde_src = `DDE_SRC_REG;
      else
        dde_src = `DDE_SRC_IND;
    end
  endfunction

  // a start that arrives while busy is dropped without notice;
  // the core is expected to wait for busy to fall
  wire [2:0] cls = dde_decode(opcode);
  wire is_dec = start && cls[0] && !busy;
  wire is_div = start && cls[2] && !busy;
  wire [1:0] src = dde_src(opcode);

  assign illegal = start && (cls == 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // operand addressing

  wire [7:0] ind_addr = opcode[0] ? pointer_register1 : pointer_register0;

  assign working_register_sel = opcode[2:0];
  assign mem_raddr = (src == `DDE_SRC_DIR) ? direct_addr : ind_addr;

  reg [7:0] dec_operand;

  always @*
  begin
    case (src)
      `DDE_SRC_ACC: dec_operand = acc_in;
      `DDE_SRC_REG: dec_operand = working_register_in;
      // port latch, never the pins, for direct port operands
      `DDE_SRC_DIR: dec_operand = dir_is_port ? port_latch : mem_rdata;
      default: dec_operand = mem_rdata;
    endcase
  end

  // modulo-256 subtract gives the 00 -> FF wrap for free
  wire [7:0] dec_result = dec_operand - `DDE_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // divide sequencer

  localparam ST_IDLE = 2'b01;
  localparam ST_DIV = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`DDE_CNT_W-1:0] cnt_q;
  reg [`DDE_CNT_W-1:0] cnt_d;
  reg [7:0] rem_q;
  reg [7:0] quo_q;
  reg [7:0] dvs_q;
  reg [7:0] rem_d;
  reg [7:0] quo_d;
  reg [7:0] dvs_d;
  wire [7:0] rem_nx;
  wire [7:0] quo_nx;

  // restoring division: the remainder starts at zero and the dividend
  // shifts out of the top of the quotient register as quotient bits enter
  // two quotient bits per cycle so eight bits fit the four cycles
  dde_div_step u_step (
    .rem_in(rem_q),
    .quo_in(quo_q),
    .divisor(dvs_q),
    .rem_out(rem_nx),
    .quo_out(quo_nx)
  );

  assign busy = (state_q == ST_DIV);

  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rem_d = rem_q;
    quo_d = quo_q;
    dvs_d = dvs_q;
    case (state_q)
      ST_IDLE:
      begin
        if (is_div)
        begin
          state_d = ST_DIV;
          cnt_d = `DDE_CNT_ZERO;
          rem_d = `DDE_ZERO;
          quo_d = acc_in;
          dvs_d = b_in;
        end
      end
      ST_DIV:
      begin
        rem_d = rem_nx;
        quo_d = quo_nx;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `DDE_CNT_LAST)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  wire div_last = (state_q == ST_DIV) && (cnt_q == `DDE_CNT_LAST);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= `DDE_CNT_ZERO;
      rem_q <= `DDE_ZERO;
      quo_q <= `DDE_ZERO;
      dvs_q <= `DDE_ZERO;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      dvs_q <= dvs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers
  // strobes default low so every write lasts exactly one cycle

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_wr <= 1'b0;
      acc_out <= `DDE_ZERO;
      b_wr <= 1'b0;
      b_out <= `DDE_ZERO;
      working_register_wr <= 1'b0;
      working_register_wsel <= 3'h0;
      working_register_out <= `DDE_ZERO;
      mem_wr <= 1'b0;
      mem_waddr <= `DDE_ZERO;
      mem_wdata <= `DDE_ZERO;
      flags_wr <= 1'b0;
      carry_out <= 1'b0;
      aux_carry_out <= 1'b0;
      overflow_flag_out <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      acc_wr <= 1'b0;
      b_wr <= 1'b0;
      working_register_wr <= 1'b0;
      mem_wr <= 1'b0;
      flags_wr <= 1'b0;
      done <= 1'b0;
      if (is_dec)
      begin
        done <= 1'b1;
        // flags pass through unchanged and flags_wr stays low
        carry_out <= carry_in;
        aux_carry_out <= aux_carry_in;
        overflow_flag_out <= overflow_flag_in;
        case (src)
          `DDE_SRC_ACC:
          begin
            acc_wr <= 1'b1;
            acc_out <= dec_result;
          end
          `DDE_SRC_REG:
          begin
            working_register_wr <= 1'b1;
            working_register_wsel <= opcode[2:0];
            working_register_out <= dec_result;
          end
          default:
          begin
            mem_wr <= 1'b1;
            mem_waddr <= mem_raddr;
            mem_wdata <= dec_result;
          end
        endcase
      end
      if (div_last)
      begin
        // quotient, remainder and flags all land in one cycle
        done <= 1'b1;
        acc_wr <= 1'b1;
        b_wr <= 1'b1;
        flags_wr <= 1'b1;
        acc_out <= quo_nx;
        b_out <= rem_nx;
        carry_out <= 1'b0;
        aux_carry_out <= aux_carry_in;
        // zero divisor: results are whatever the steps left
        // it still runs all four cycles, so timing never depends on data
        overflow_flag_out <= (dvs_q == `DDE_ZERO);
      end
    end
  end

endmodule

`default_nettype wire

// [verification/dde_core_model.sv]
// Purpose: core-side data memory facing the decrement/divide datapath
// Assumes: operand reads are combinational in the taking cycle
// Notes: unwritten bytes stay unknown, so stray reads show up
`timescale 1ns/1ps
`default_nettype none
module dde_core_model (
  // clock
  input wire clk,
  // memory ports
  input wire [7:0] mem_raddr,
  input wire mem_wr,
  input wire [7:0] mem_waddr,
  input wire [7:0] mem_wdata,
  output wire [7:0] mem_rdata
);
  logic [7:0] ram [0:255];
  assign mem_rdata = ram[mem_raddr];
  always @(posedge clk)
  begin
    if (mem_wr)
      ram[mem_waddr] <= mem_wdata;
  end
endmodule
`default_nettype wire

// [verification/dde_exec_monitor.sv]
// Purpose: port-level assertions for the decrement/divide datapath
// Assumes: one clock domain, reset_n asynchronous active low
// Notes: bound to every dde_exec instance
`timescale 1ns/1ps
`default_nettype none
module dde_exec_monitor (
  // clock, reset, request
  input wire clk, reset_n, start, busy, dir_is_port,
  input wire [7:0] opcode, direct_addr, acc_in, b_in, working_register_in,
  input wire [7:0] pointer_register0, pointer_register1, mem_rdata, port_latch,
  // results
  input wire [2:0] working_register_sel, working_register_wsel,
  input wire [7:0] mem_raddr, acc_out, b_out, working_register_out, mem_waddr, mem_wdata,
  input wire acc_wr, b_wr, working_register_wr, mem_wr, flags_wr,
  input wire carry_out, overflow_flag_out, done, illegal
);
  wire go = start && !busy;
  wire dec_reg = go && opcode[7:3] == 5'h03;
  wire dec_ind = go && opcode[7:1] == 7'h0B;
  wire is_div = go && opcode == 8'h84;
  wire known = dec_reg || dec_ind || is_div || opcode == 8'h14 || opcode == 8'h15;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  a_acc_wrap: assert property (go && opcode == 8'h14 |=> acc_wr && done
    && acc_out == $past(acc_in) - 8'h01) else $error("acc decrement wrong");
  a_dec_flags: assert property (go && opcode[7:4] == 4'h1 |=> !flags_wr)
    else $error("decrement touched flags");
  a_reg_result: assert property (dec_reg |-> working_register_sel == opcode[2:0] ##1
    working_register_wr && working_register_wsel == $past(working_register_sel)
    && working_register_out == $past(working_register_in) - 8'h01)
    else $error("register decrement wrong");
  a_dir_port: assert property (go && opcode == 8'h15 |-> mem_raddr == direct_addr ##1
    mem_wr && mem_waddr == $past(direct_addr) && mem_wdata ==
    ($past(dir_is_port) ? $past(port_latch) : $past(mem_rdata)) - 8'h01)
    else $error("direct decrement wrong");
  a_ind_ptr: assert property (dec_ind
    |-> mem_raddr == (opcode[0] ? pointer_register1 : pointer_register0) ##1
    mem_wr && mem_waddr == $past(mem_raddr) && mem_wdata == $past(mem_rdata) - 8'h01)
    else $error("indirect decrement wrong");
  a_div_span: assert property (is_div |=> busy[*4] ##1
    (!busy && acc_wr && b_wr && flags_wr && done)) else $error("divide timing wrong");
  a_div_quot: assert property (is_div && b_in != 8'h00 |-> ##5
    acc_out == $past(acc_in, 5) / $past(b_in, 5) && b_out == $past(acc_in, 5) % $past(b_in, 5)
    && !carry_out && !overflow_flag_out) else $error("divide result wrong");
  a_div_zero: assert property (is_div && b_in == 8'h00 |-> ##5
    overflow_flag_out && !carry_out) else $error("zero divisor flags wrong");
  a_busy_quiet: assert property (busy |-> !done && !acc_wr && !mem_wr
    && !working_register_wr) else $error("write during divide");
  a_illegal_nop: assert property (go && !known |-> illegal ##1
    !(acc_wr || b_wr || mem_wr || working_register_wr || flags_wr))
    else $error("unknown opcode wrote");
  c_div_zero: cover property (is_div && b_in == 8'h00);
  c_ind_one: cover property (dec_ind && opcode[0]);
  c_port: cover property (go && opcode == 8'h15 && dir_is_port);
endmodule
bind dde_exec dde_exec_monitor mon (.*);
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench for the decrement/divide datapath
// Assumes: one clock cycle per machine cycle
// Notes: the core model holds the data memory
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, reset_n, start, dir_is_port, carry_in, aux_carry_in, overflow_flag_in;
  logic [7:0] opcode, direct_addr, acc_in, b_in, working_register_in, port_latch;
  logic [7:0] pointer_register0, pointer_register1;
  wire [7:0] mem_rdata, mem_raddr, acc_out, b_out, working_register_out, mem_waddr, mem_wdata;
  wire [2:0] working_register_sel, working_register_wsel;
  wire acc_wr, b_wr, working_register_wr, mem_wr, flags_wr, carry_out, aux_carry_out;
  wire overflow_flag_out, busy, done, illegal;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  dde_exec uut (.*);
  dde_core_model core (.*);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // generous ceiling: the whole run needs well under 200 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      fail_count++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // flags are driven to the inverse of b so clearing and keeping both show
  task automatic issue(input logic [7:0] op, a, b, input logic p);
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    {acc_in, working_register_in, port_latch, b_in} <= {a, a, a, b};
    {overflow_flag_in, aux_carry_in, carry_in} <= ~b[2:0];
    dir_is_port <= p;
    direct_addr <= 8'h40 + {7'h00, p};
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_acc;
    issue(8'h14, 8'h00, 8'h00, 1'b0);
    chk(acc_out, 8'hFF);
    chk({acc_wr, done, flags_wr}, 3'h6);
    chk({overflow_flag_out, aux_carry_out, carry_out}, 3'h7);
    issue(8'h14, 8'h80, 8'h05, 1'b0);
    chk(acc_out, 8'h7F);
    $display("test acc decrement finished");
  endtask
  task automatic t_reg;
    for (int r = 0; r < 8; r++)
    begin
      issue(8'h18 | r[7:0], r[7:0], 8'h00, 1'b0);
      chk(working_register_wsel, r[2:0]);
      chk(working_register_out, {r[7:0] - 8'h01});
    end
    $display("test register decrement finished");
  endtask
  task automatic t_mem;
    issue(8'h15, 8'h33, 8'h00, 1'b0);
    chk({mem_waddr, mem_wdata}, 16'h40FF);
    issue(8'h15, 8'h5A, 8'h00, 1'b1);
    chk(mem_wdata, 8'h59);
    issue(8'h16, 8'h00, 8'h00, 1'b0);
    chk({mem_waddr, mem_wdata}, 16'h7EFF);
    issue(8'h17, 8'h00, 8'h00, 1'b0);
    chk({mem_waddr, mem_wdata}, 16'h7F3F);
    @(posedge clk);
    #1 chk(core.ram[8'h7F], 8'h3F);
    $display("test memory decrement finished");
  endtask
  // a decrement request lands mid-divide and must be dropped
  task automatic t_div(input logic [7:0] a, b, q, r);
    issue(8'h84, a, b, 1'b0);
    chk(busy, 1'b1);
    @(posedge clk);
    start <= 1'b1;
    opcode <= 8'h14;
    @(posedge clk);
    start <= 1'b0;
    #1 chk(acc_wr, 1'b0);
    @(posedge clk);
    #1 chk(busy, 1'b1);
    @(posedge clk);
    #1 chk({busy, acc_wr, b_wr, flags_wr, done}, 5'h0F);
    chk({carry_out, overflow_flag_out}, {1'b0, b == 8'h00});
    if (b != 8'h00)
      chk({acc_out, b_out}, {q, r});
    $display("test divide %h by %h finished", a, b);
  endtask
  task automatic t_bad;
    @(posedge clk);
    start <= 1'b1;
    opcode <= 8'h13;
    #1 chk(illegal, 1'b1);
    @(posedge clk);
    start <= 1'b0;
    #1 chk({acc_wr, mem_wr, working_register_wr, done}, 4'h0);
    $display("test unknown opcode finished");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    {start, dir_is_port, carry_in, aux_carry_in, overflow_flag_in} = 5'h00;
    {opcode, direct_addr, acc_in, b_in, working_register_in, port_latch} = 48'h0;
    {pointer_register0, pointer_register1} = 16'h7E7F;
    {core.ram[8'h40], core.ram[8'h41], core.ram[8'h7E], core.ram[8'h7F]} = 32'h00000040;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_acc();
    t_reg();
    t_mem();
    t_div(8'hFB, 8'h12, 8'h0D, 8'h11);
    t_div(8'hFF, 8'h01, 8'hFF, 8'h00);
    t_div(8'h05, 8'h0A, 8'h00, 8'h05);
    t_div(8'h07, 8'h00, 8'h00, 8'h00);
    t_bad();
    test_done();
  end
endmodule
`default_nettype wire
